// ==== hw/initial_speed_detect_config.sv ====
`timescale 1ns/1ps
// What this block does
// - hold the 32-bit float sliding gain, read/write, and feed the estimator
// - run speed detection at start only when enable bit 29 is set; resets to 0
// - resync allowed only at or above coded speed threshold, 5..60 then 70..100 percent
// - brake exit select 0: leave brake once brake duration has elapsed
// - brake exit select 1: leave brake when phase current drops below threshold
// - brake duration code maps to 10ms through 15s in table order
// - motor stationary when back-emf is below the coded 50..1500 mV threshold
module initial_speed_detect_config
    import speed_detect_pkg::*;
#(
    parameter int TICK_CYCLES = speed_detect_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic                        sys_clk_i,
    input  wire logic                        reset_i,
    // register bus
    input  wire speed_detect_pkg::axil_req_t axi_req_i,
    output      speed_detect_pkg::axil_rsp_t axi_rsp_o,
    // start request and measurements
    input  wire logic                        start_req_i,
    input  wire logic [6:0]                  speed_pct_i,
    input  wire logic                        speed_fwd_i,
    input  wire logic [15:0]                 bemf_mv_i,
    input  wire logic                        brake_current_low_i,
    // estimator and drive outputs
    output      logic [31:0]                 sliding_gain_o,
    output      logic                        detect_busy_o,
    output      logic                        resync_o,
    output      logic                        normal_start_o,
    output      logic                        brake_o,
    output      logic                        coast_o,
    output      logic                        reverse_drive_o
);
    import speed_detect_pkg::*;

    reg_wr_t     wr;
    logic [31:0] rd_addr, rd_data;
    logic        rd_err, wr_err;
    logic [31:0] gain_q, gain_d, cfg_q, cfg_d;
    state_t      state_q, state_d;
    logic        stat_q, stat_d, spin_q, spin_d;
    logic        timer_load, timer_done;
    logic [13:0] timer_ms;
    logic [5:0]  outs_q, outs_d;
    logic        stationary, resync_ok;

    // address match on an aligned word
    function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
        hit = (a[31:2] == off[31:2]);
    endfunction : hit

    // byte-lane merge
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        merge = r;
    endfunction : merge

    // bus slave
    axil_slave u_bus (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .axi_req_i (axi_req_i),
        .axi_rsp_o (axi_rsp_o),
        .wr_o      (wr),
        .wr_err_i  (wr_err),
        .rd_addr_o (rd_addr),
        .rd_data_i (rd_data),
        .rd_err_i  (rd_err)
    );

    // duration timer for brake and coast
    ms_timer #(.TICK(TICK_CYCLES)) u_timer (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .load_i    (timer_load),
        .load_ms_i (timer_ms),
        .done_o    (timer_done)
    );

    // register write decode
    always_comb begin
        gain_d = gain_q;
        cfg_d  = cfg_q;
        wr_err = !(hit(wr.addr, GAIN_OFFSET) || hit(wr.addr, CONFIG_OFFSET)
                   || hit(wr.addr, STATUS_OFFSET));
        if (wr.en && hit(wr.addr, GAIN_OFFSET)) begin
            gain_d = merge(gain_q, wr.data, wr.strb);
        end
        if (wr.en && hit(wr.addr, CONFIG_OFFSET)) begin
            cfg_d = merge(cfg_q, wr.data, wr.strb) & CONFIG_WMASK;
        end
    end

    // register read decode
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err  = 1'b0;
        if (hit(rd_addr, GAIN_OFFSET)) begin
            rd_data = gain_q;
        end else if (hit(rd_addr, CONFIG_OFFSET)) begin
            rd_data = cfg_q;
        end else if (hit(rd_addr, STATUS_OFFSET)) begin
            rd_data[ST_STATE_LSB +: 3]  = state_q;
            rd_data[ST_STATIONARY_BIT]  = stat_q;
            rd_data[ST_SPINNING_BIT]    = spin_q;
            rd_data[ST_BUSY_BIT]        = outs_q[0];
        end else begin
            rd_err = 1'b1;
        end
    end

    // register file
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            gain_q <= GAIN_RESET;
            cfg_q  <= CONFIG_RESET;
        end else begin
            gain_q <= gain_d;
            cfg_q  <= cfg_d;
        end
    end

    // threshold comparisons
    assign stationary = bemf_mv_i < STAT_MV[cfg_q[STAT_THR_LSB +: 3]];
    assign resync_ok  = cfg_q[RESYNC_ENABLE_BIT] && speed_fwd_i
                        && (speed_pct_i >= resync_pct(cfg_q[RESYNC_THR_LSB +: 4]));

    // start-up sequencer
    always_comb begin
        state_d    = state_q;
        stat_d     = stat_q;
        spin_d     = spin_q;
        timer_load = 1'b0;
        timer_ms   = DURATION_MS[cfg_q[BRAKE_DUR_LSB +: 4]];
        unique case (state_q)
            ST_IDLE: begin
                if (start_req_i) begin
                    state_d = cfg_q[DETECT_EN_BIT] ? ST_DETECT : ST_START;
                end
            end
            ST_DETECT: begin
                stat_d = stationary;
                spin_d = !stationary;
                if (stationary) begin
                    state_d = ST_START;
                end else if (resync_ok) begin
                    state_d = ST_RESYNC;
                end else if (cfg_q[REVERSE_EN_BIT] && !speed_fwd_i) begin
                    state_d = ST_REVERSE;
                end else if (cfg_q[BRAKE_EN_BIT]) begin
                    state_d    = ST_BRAKE;
                    timer_load = 1'b1;
                end else if (cfg_q[COAST_EN_BIT]) begin
                    state_d    = ST_COAST;
                    timer_load = 1'b1;
                    timer_ms   = DURATION_MS[cfg_q[COAST_DUR_LSB +: 4]];
                end else begin
                    state_d = ST_START;
                end
            end
            ST_REVERSE: begin
                if (stationary) begin
                    state_d = ST_START;
                end
            end
            ST_BRAKE: begin
                if (cfg_q[BRAKE_SEL_BIT]) begin
                    if (brake_current_low_i) begin
                        state_d = ST_START;
                    end
                end else if (timer_done) begin
                    state_d = ST_START;
                end
            end
            ST_COAST: begin
                if (timer_done) begin
                    state_d = ST_START;
                end
            end
            ST_RESYNC: state_d = ST_IDLE;
            ST_START:  state_d = ST_IDLE;
        endcase
    end

    // output decode from next state
    always_comb begin
        outs_d[0] = state_d != ST_IDLE;
        outs_d[1] = state_d == ST_RESYNC;
        outs_d[2] = state_d == ST_START;
        outs_d[3] = state_d == ST_BRAKE;
        outs_d[4] = state_d == ST_COAST;
        outs_d[5] = state_d == ST_REVERSE;
    end

    // sequencer registers
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            state_q <= ST_IDLE;
            stat_q  <= 1'b0;
            spin_q  <= 1'b0;
            outs_q  <= 6'h00;
        end else begin
            state_q <= state_d;
            stat_q  <= stat_d;
            spin_q  <= spin_d;
            outs_q  <= outs_d;
        end
    end

    // outputs straight from flops
    assign sliding_gain_o  = gain_q;
    assign detect_busy_o   = outs_q[0];
    assign resync_o        = outs_q[1];
    assign normal_start_o  = outs_q[2];
    assign brake_o         = outs_q[3];
    assign coast_o         = outs_q[4];
    assign reverse_drive_o = outs_q[5];

    // checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    gain_write_a: assert property (
        (wr.en && hit(wr.addr, GAIN_OFFSET) && wr.strb == 4'hf)
        |=> sliding_gain_o == $past(wr.data))
        else $error("sliding gain not updated by full write");

    skip_detect_a: assert property (
        (state_q == ST_IDLE && start_req_i && !cfg_q[DETECT_EN_BIT])
        |=> (normal_start_o && state_q == ST_START) ##1 state_q == ST_IDLE)
        else $error("disabled detection did not go straight to start");

    resync_thr_a: assert property (
        $rose(resync_o) |-> $past(speed_pct_i)
            >= resync_pct($past(cfg_q[RESYNC_THR_LSB +: 4])))
        else $error("resync below speed threshold");

    brake_time_a: assert property (
        (state_q == ST_BRAKE && !cfg_q[BRAKE_SEL_BIT] && !timer_done)
        |=> brake_o)
        else $error("brake left before duration elapsed");

    brake_current_a: assert property (
        (state_q == ST_BRAKE && cfg_q[BRAKE_SEL_BIT] && brake_current_low_i)
        |=> !brake_o && normal_start_o)
        else $error("brake not left on low current");

    brake_load_a: assert property (
        (state_q == ST_DETECT && state_d == ST_BRAKE)
        |-> timer_load && timer_ms == DURATION_MS[cfg_q[BRAKE_DUR_LSB +: 4]])
        else $error("brake duration not loaded from code");

    stationary_a: assert property (
        (state_q == ST_DETECT && stationary) |=> normal_start_o ##1 !detect_busy_o)
        else $error("stationary motor not started normally");

    spin_brake_a: assert property (
        (state_q == ST_DETECT && !stationary && !resync_ok
         && !(cfg_q[REVERSE_EN_BIT] && !speed_fwd_i) && cfg_q[BRAKE_EN_BIT])
        |=> brake_o ##1 (brake_o || normal_start_o))
        else $error("spinning motor not braked");

    resync_once_a: assert property (
        resync_o |=> !resync_o)
        else $error("resync pulse too long");

    start_once_a: assert property (
        normal_start_o |=> !normal_start_o)
        else $error("start pulse too long");

    coast_time_a: assert property (
        (state_q == ST_COAST && !timer_done) |=> coast_o)
        else $error("coast left early");

    reverse_exit_a: assert property (
        (state_q == ST_REVERSE && stationary) |=> normal_start_o)
        else $error("reverse not ended");

    detect_run_a: assert property (
        (state_q == ST_IDLE && start_req_i && cfg_q[DETECT_EN_BIT]) |=> state_q == ST_DETECT)
        else $error("detection skipped");

    gain_hold_a: assert property (
        !(wr.en && hit(wr.addr, GAIN_OFFSET)) |=> $stable(sliding_gain_o))
        else $error("gain changed without write");

    resync_cov_c:  cover property (state_q == ST_DETECT ##1 resync_o);
    brake_cur_c:   cover property (brake_o && cfg_q[BRAKE_SEL_BIT] ##1 normal_start_o);
    coast_done_c:  cover property (coast_o ##1 normal_start_o);
    reverse_c:     cover property (reverse_drive_o ##1 normal_start_o);
    skip_c:        cover property (start_req_i && !cfg_q[DETECT_EN_BIT]);

endmodule : initial_speed_detect_config

// ==== hw/speed_detect_pkg.sv ====
package speed_detect_pkg;

    // register byte addresses
    localparam logic [31:0] GAIN_OFFSET    = 32'h0000_0038;
    localparam logic [31:0] CONFIG_OFFSET  = 32'h0000_003c;
    localparam logic [31:0] STATUS_OFFSET  = 32'h0000_0080;

    // reset values and writable bits
    localparam logic [31:0] GAIN_RESET     = 32'h0000_0000;
    localparam logic [31:0] CONFIG_RESET   = 32'h0000_0000;
    localparam logic [31:0] CONFIG_WMASK   = 32'h3fff_fe00;

    // config field positions
    localparam int DETECT_EN_BIT      = 29;
    localparam int BRAKE_EN_BIT       = 28;
    localparam int COAST_EN_BIT       = 27;
    localparam int REVERSE_EN_BIT     = 26;
    localparam int RESYNC_ENABLE_BIT      = 25;
    localparam int RESYNC_THR_LSB     = 21;
    localparam int BRAKE_SEL_BIT      = 20;
    localparam int BRAKE_DUR_LSB      = 16;
    localparam int COAST_DUR_LSB      = 12;
    localparam int STAT_THR_LSB       = 9;

    // status field positions
    localparam int ST_STATE_LSB       = 0;
    localparam int ST_STATIONARY_BIT  = 4;
    localparam int ST_SPINNING_BIT    = 5;
    localparam int ST_BUSY_BIT        = 8;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // timing: one millisecond tick at the system clock
    localparam int CLK_PERIOD_NS = 100;
    localparam int MS_NS         = 1000000;
    localparam int TICK_CYCLES   = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PRE_W         = 16;
    localparam int MS_W          = 14;

    // duration table in milliseconds
    localparam logic [13:0] DURATION_MS [16] = '{
        14'd10,   14'd50,   14'd100,  14'd200,
        14'd300,  14'd400,  14'd500,  14'd750,
        14'd1000, 14'd2000, 14'd3000, 14'd4000,
        14'd5000, 14'd7500, 14'd10000, 14'd15000
    };

    // stationary back-emf thresholds in millivolts
    localparam logic [15:0] STAT_MV [8] = '{
        16'd50, 16'd75, 16'd100, 16'd250,
        16'd500, 16'd750, 16'd1000, 16'd1500
    };

    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE, ST_DETECT, ST_RESYNC, ST_REVERSE, ST_BRAKE, ST_COAST, ST_START
    } state_t;

    // axi4-lite master to slave
    typedef struct packed {
        logic [31:0] awaddr;
        logic [2:0]  awprot;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [31:0] araddr;
        logic [2:0]  arprot;
        logic        arvalid;
        logic        rready;
    } axil_req_t;

    // axi4-lite slave to master
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic [1:0]  bresp;
        logic        bvalid;
        logic        arready;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        rvalid;
    } axil_rsp_t;

    // register write strobe
    typedef struct packed {
        logic        en;
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } reg_wr_t;

    // resync threshold in percent of max speed
    function automatic logic [6:0] resync_pct(input logic [3:0] code);
        if (code < 4'hc) begin
            resync_pct = 7'(5 * (int'(code) + 1));
        end else begin
            resync_pct = 7'(70 + 10 * (int'(code) - 12));
        end
    endfunction : resync_pct

endpackage : speed_detect_pkg

// ==== hw/axil_slave.sv ====
`timescale 1ns/1ps
module axil_slave
    import speed_detect_pkg::*;
(
    // clock and reset
    input  wire logic                        sys_clk_i,
    input  wire logic                        reset_i,
    // bus
    input  wire speed_detect_pkg::axil_req_t axi_req_i,
    output      speed_detect_pkg::axil_rsp_t axi_rsp_o,
    // register side
    output      speed_detect_pkg::reg_wr_t   wr_o,
    input  wire logic                        wr_err_i,
    output      logic [31:0]                 rd_addr_o,
    input  wire logic [31:0]                 rd_data_i,
    input  wire logic                        rd_err_i
);
    logic        aw_held_q, aw_held_d, w_held_q, w_held_d;
    logic [31:0] awaddr_q, awaddr_d, wdata_q, wdata_d;
    logic [3:0]  wstrb_q, wstrb_d;
    axil_rsp_t   rsp_q, rsp_d;
    logic        do_write;

    // write fires once address and data are both held
    assign do_write       = aw_held_q && w_held_q && !rsp_q.bvalid;
    assign wr_o.en        = do_write;
    assign wr_o.addr      = awaddr_q;
    assign wr_o.data      = wdata_q;
    assign wr_o.strb      = wstrb_q;
    assign rd_addr_o      = axi_req_i.araddr;
    assign axi_rsp_o      = rsp_q;

    // channel next state
    always_comb begin
        aw_held_d = aw_held_q;
        w_held_d  = w_held_q;
        awaddr_d  = awaddr_q;
        wdata_d   = wdata_q;
        wstrb_d   = wstrb_q;
        rsp_d     = rsp_q;
        if (axi_req_i.awvalid && rsp_q.awready) begin
            aw_held_d = 1'b1;
            awaddr_d  = axi_req_i.awaddr;
        end
        if (axi_req_i.wvalid && rsp_q.wready) begin
            w_held_d = 1'b1;
            wdata_d  = axi_req_i.wdata;
            wstrb_d  = axi_req_i.wstrb;
        end
        if (rsp_q.bvalid && axi_req_i.bready) begin
            rsp_d.bvalid = 1'b0;
        end
        if (do_write) begin
            aw_held_d    = 1'b0;
            w_held_d     = 1'b0;
            rsp_d.bvalid = 1'b1;
            rsp_d.bresp  = wr_err_i ? RESP_SLVERR : RESP_OKAY;
        end
        if (rsp_q.rvalid && axi_req_i.rready) begin
            rsp_d.rvalid = 1'b0;
        end
        if (axi_req_i.arvalid && rsp_q.arready) begin
            rsp_d.rvalid = 1'b1;
            rsp_d.rdata  = rd_data_i;
            rsp_d.rresp  = rd_err_i ? RESP_SLVERR : RESP_OKAY;
        end
        rsp_d.awready = !aw_held_d && !rsp_d.bvalid;
        rsp_d.wready  = !w_held_d && !rsp_d.bvalid;
        rsp_d.arready = !rsp_d.rvalid;
    end

    // channel registers
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= 32'h0000_0000;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            rsp_q     <= '0;
        end else begin
            aw_held_q <= aw_held_d;
            w_held_q  <= w_held_d;
            awaddr_q  <= awaddr_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            rsp_q     <= rsp_d;
        end
    end
endmodule : axil_slave

// ==== hw/ms_timer.sv ====
`timescale 1ns/1ps
module ms_timer
    import speed_detect_pkg::*;
#(
    parameter int TICK = speed_detect_pkg::TICK_CYCLES
) (
    // clock and reset
    input  wire logic                              sys_clk_i,
    input  wire logic                              reset_i,
    // control
    input  wire logic                              load_i,
    input  wire logic [speed_detect_pkg::MS_W-1:0] load_ms_i,
    output      logic                              done_o
);
    logic [PRE_W-1:0] pre_q, pre_d;
    logic [MS_W-1:0]  ms_q, ms_d;
    logic             done_q, done_d;

    assign done_o = done_q;

    // millisecond prescaler and countdown
    always_comb begin
        pre_d  = pre_q;
        ms_d   = ms_q;
        done_d = done_q;
        if (load_i) begin
            pre_d  = '0;
            ms_d   = load_ms_i;
            done_d = 1'b0;
        end else if (!done_q) begin
            if (pre_q == PRE_W'(TICK - 1)) begin
                pre_d = '0;
                if (ms_q <= MS_W'(1)) begin
                    ms_d   = '0;
                    done_d = 1'b1;
                end else begin
                    ms_d = ms_q - MS_W'(1);
                end
            end else begin
                pre_d = pre_q + PRE_W'(1);
            end
        end
    end

    // timer registers
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            pre_q  <= '0;
            ms_q   <= '0;
            done_q <= 1'b1;
        end else begin
            pre_q  <= pre_d;
            ms_q   <= ms_d;
            done_q <= done_d;
        end
    end
endmodule : ms_timer

// ==== testbench/motor_model.sv ====
`timescale 1ns/1ps
module motor_model (
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        reset_i,
    // motor state wanted by the bench
    input  wire logic [6:0]  set_pct_i,
    input  wire logic        set_fwd_i,
    input  wire logic [15:0] set_mv_i,
    input  wire logic [7:0]  cur_delay_i,
    // drive commands
    input  wire logic        brake_i,
    input  wire logic        reverse_i,
    // measurements
    output      logic [6:0]  speed_pct_o,
    output      logic        speed_fwd_o,
    output      logic [15:0] bemf_mv_o,
    output      logic        current_low_o
);
    logic [15:0] bemf_q, bemf_d;
    logic [7:0]  cnt_q, cnt_d;

    // reverse drive pulls the back-emf down, brake time counts up
    always_comb begin
        bemf_d = (bemf_q > 16'h32) ? bemf_q - 16'h32 : 16'h0;
        if (!reverse_i) begin
            bemf_d = set_mv_i;
        end
        cnt_d = (brake_i && cnt_q != 8'hff) ? cnt_q + 8'h1 : 8'h0;
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            bemf_q <= 16'h0;
            cnt_q  <= 8'h0;
        end else begin
            bemf_q <= bemf_d;
            cnt_q  <= cnt_d;
        end
    end

    assign speed_pct_o   = set_pct_i;
    assign speed_fwd_o   = set_fwd_i;
    assign bemf_mv_o     = bemf_q;
    // winding current decays a set time after braking starts
    assign current_low_o = brake_i && (cnt_q >= cur_delay_i);
endmodule : motor_model

// ==== testbench/initial_speed_detect_config_test.sv ====
`timescale 1ns/1ps
module initial_speed_detect_config_test;
    import speed_detect_pkg::*;
    localparam int DET = 1 << DETECT_EN_BIT;
    localparam int BRK = 1 << BRAKE_EN_BIT;
    localparam int CST = 1 << COAST_EN_BIT;
    localparam int REV = 1 << REVERSE_EN_BIT;
    localparam int RSY = 1 << RESYNC_ENABLE_BIT;
    localparam int SEL = 1 << BRAKE_SEL_BIT;
    logic        sys_clk_i, reset_i, start_req_i, fwd, set_fwd, cur_low;
    logic        resync, nstart, brake, coast, reverse, busy;
    logic [6:0]  pct, set_pct;
    logic [15:0] mv, set_mv;
    logic [7:0]  cur_dly;
    logic [31:0] gain, g;
    axil_req_t   req;
    axil_rsp_t   rsp;
    int          n_fail, checks_done, c, s;

    // one-cycle millisecond keeps the long durations short
    initial_speed_detect_config #(.TICK_CYCLES(1)) uut (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .axi_req_i(req), .axi_rsp_o(rsp),
        .start_req_i(start_req_i), .speed_pct_i(pct), .speed_fwd_i(fwd), .bemf_mv_i(mv),
        .brake_current_low_i(cur_low), .sliding_gain_o(gain), .detect_busy_o(busy),
        .resync_o(resync), .normal_start_o(nstart), .brake_o(brake), .coast_o(coast),
        .reverse_drive_o(reverse)
    );

    motor_model motor (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .set_pct_i(set_pct), .set_fwd_i(set_fwd),
        .set_mv_i(set_mv), .cur_delay_i(cur_dly), .brake_i(brake), .reverse_i(reverse),
        .speed_pct_o(pct), .speed_fwd_o(fwd), .bemf_mv_o(mv), .current_low_o(cur_low)
    );

    initial begin
        sys_clk_i = 1'b0;
        forever #50 sys_clk_i = ~sys_clk_i;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask : check

    task automatic hang(input string nm);
        $display("[FAIL] %s expected answer seen timeout", nm);
        n_fail++;
        conclude();
    endtask : hang

    // bus write, address and data offered together
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge sys_clk_i);
        req.awaddr  <= a;
        req.wdata   <= d;
        req.wstrb   <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid  <= 1'b1;
        req.bready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk_i);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid === 1'b1) break;
        end
        req.bready <= 1'b0;
        if (n == 50) hang("bvalid");
        check("bresp", 32'(er), 32'(rsp.bresp));
    endtask : axi_wr

    task automatic axi_rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge sys_clk_i);
        req.araddr  <= a;
        req.arvalid <= 1'b1;
        req.rready  <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk_i);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid === 1'b1) break;
        end
        req.rready <= 1'b0;
        if (n == 50) hang("rvalid");
        check("rresp", 32'(er), 32'(rsp.rresp));
        check("rdata", ed, rsp.rdata);
    endtask : axi_rd

    // reference decision of the detection sequence
    function automatic int predict(input int cfg, input int spd, input int dir, input int emf);
        int t;
        t = (cfg >> RESYNC_THR_LSB) & 15;
        t = (t < 12) ? 5 * t + 5 : 10 * t - 50;
        if (!cfg[DETECT_EN_BIT] || emf < STAT_MV[(cfg >> STAT_THR_LSB) & 7]) return 2;
        if (cfg[RESYNC_ENABLE_BIT] && dir != 0 && spd >= t) return 1;
        if (cfg[REVERSE_EN_BIT] && dir == 0) return 5;
        if (cfg[BRAKE_EN_BIT]) return 3;
        return cfg[COAST_EN_BIT] ? 4 : 2;
    endfunction : predict

    // configure, set the motor, request a start and follow the outcome
    task automatic run(input int cfg, input int spd, input int dir, input int emf,
                       input int dly, input int lo, input int hi);
        int k, cur, len, n;
        axi_wr(32'h3c, 32'(cfg), RESP_OKAY);
        set_pct <= 7'(spd);
        set_fwd <= 1'(dir);
        set_mv  <= 16'(emf);
        cur_dly <= 8'(dly);
        repeat (3) @(posedge sys_clk_i);
        start_req_i <= 1'b1;
        @(posedge sys_clk_i);
        start_req_i <= 1'b0;
        k = 0;
        len = 0;
        for (n = 0; n < 20000; n++) begin
            @(posedge sys_clk_i);
            case (1'b1)
                resync:  cur = 1;
                nstart:  cur = 2;
                brake:   cur = 3;
                coast:   cur = 4;
                reverse: cur = 5;
                default: cur = 0;
            endcase
            if (cur > 2) len++;
            if (k == 0) k = cur;
            if (cur == 1 || cur == 2) break;
        end
        if (n == 20000) hang("start outcome");
        check("action", predict(cfg, spd, dir, emf), k);
        checks_done++;
        if (k > 2 && (len < lo || len > hi)) begin
            $display("[FAIL] duration expected %0d..%0d seen %0d", lo, hi, len);
            n_fail++;
        end
        repeat (2) @(posedge sys_clk_i);
        check("detect_busy_o", 32'h0, 32'(busy));
    endtask : run

    initial begin
        req         = '0;
        reset_i     = 1'b1;
        start_req_i = 1'b0;
        set_pct     = 7'h0;
        set_fwd     = 1'b1;
        set_mv      = 16'h0;
        cur_dly     = 8'h0;
        n_fail      = 0;
        checks_done = 0;
        g           = $urandom(32'h188f);
        repeat (5) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        // reset values, unmapped place, random register traffic
        axi_rd(32'h38, 32'h0, RESP_OKAY);
        axi_rd(32'h3c, 32'h0, RESP_OKAY);
        axi_rd(32'h40, 32'h0, RESP_SLVERR);
        axi_wr(32'h40, 32'hffff_ffff, RESP_SLVERR);
        for (c = 0; c < 4; c++) begin
            g = $urandom;
            axi_wr(32'h38, g, RESP_OKAY);
            axi_rd(32'h38, g, RESP_OKAY);
            check("sliding_gain_o", g, gain);
            g = $urandom;
            axi_wr(32'h3c, g, RESP_OKAY);
            axi_rd(32'h3c, g & 32'h3fff_fe00, RESP_OKAY);
        end
        $display("register test done");
        run(BRK | CST, 50, 1, 2000, 0, 0, 0);
        for (c = 0; c < 8; c++) begin
            for (s = 0; s < 2; s++) begin
                run(DET | CST | (c << STAT_THR_LSB), 0, 1, STAT_MV[c] - 1 + s, 0, 10, 12);
            end
        end
        $display("stationary test done");
        for (c = 0; c < 16; c++) begin
            for (s = 0; s < 2; s++) begin
                run(DET | RSY | CST | (c << RESYNC_THR_LSB), s + ((c < 12) ? 5 * c + 4 :
                    10 * c - 51), 1, 2000, 0, 10, 12);
            end
        end
        run(DET | RSY | CST, 100, 0, 2000, 0, 10, 12);
        $display("resync test done");
        for (c = 0; c < 16; c++) begin
            run(DET | BRK | (c << BRAKE_DUR_LSB), 50, 1, 2000, 0, DURATION_MS[c],
                DURATION_MS[c] + 2);
        end
        run(DET | BRK | SEL | (15 << BRAKE_DUR_LSB), 50, 1, 2000, 30, 30, 34);
        $display("brake test done");
        run(DET | REV | BRK | (3 << STAT_THR_LSB), 50, 0, 1000, 0, 15, 22);
        axi_rd(32'h80, 32'h20, RESP_OKAY);
        $display("reverse test done");
        conclude();
    end
endmodule : initial_speed_detect_config_test
